// >>> core/sbas_regs.vh
// Register offsets, fields, reset values and timing counts of the brake and alarm sequencer.
`ifndef SBAS_REGS_VH
`define SBAS_REGS_VH
`define SBAS_CLK_HZ            50000000
`define SBAS_TICK_MS           10
`define SBAS_TICK_CYC          ((`SBAS_CLK_HZ / 1000) * `SBAS_TICK_MS)
`define SBAS_ADR_CTRL          4'h0
`define SBAS_ADR_DELAY         4'h1
`define SBAS_ADR_SPEED         4'h2
`define SBAS_ADR_TMO           4'h3
`define SBAS_ADR_FAULT         4'h4
`define SBAS_ADR_STATUS        4'h5
`define SBAS_ADR_MAXSPD        4'h6
`define SBAS_DELAY_MAX         6'h32
`define SBAS_DELAY_RST         6'h00
`define SBAS_SPEED_MAX         14'h2710
`define SBAS_SPEED_RST         14'h0064
`define SBAS_TMO_MAX           7'h64
`define SBAS_TMO_RST           7'h32
`define SBAS_MAXSPD_RST        14'h1770
`define SBAS_ENMAP_IGNORE      3'h7
`define SBAS_CTRL_ROUTE_LSB    0
`define SBAS_CTRL_ENMAP_LSB    2
`define SBAS_CTRL_POSMODE_BIT  5
`define SBAS_CTRL_OTHER_LSB    6
`define SBAS_FAULT_CODE_LSB    0
`define SBAS_FAULT_ENC_BIT     3
`define SBAS_FAULT_TRAJ_BIT    4
`endif

// >>> core/sbas_sync.v
// Two-stage synchroniser for asynchronous pin inputs.
`timescale 1ns/100ps
module sbas_sync #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         ce_i,
  input  wire [W-1:0] rst_val_i,
  input  wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= rst_val_i;
      sync_q <= rst_val_i;
    end else if (ce_i) begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule // sbas_sync

// >>> core/sbas_tick.v
// Divider producing a one-cycle pulse every 10 ms control tick.
`timescale 1ns/100ps
`include "sbas_regs.vh"
module sbas_tick (
  input  wire clk_i,
  input  wire rst_i,
  input  wire ce_i,
  output wire tick_o
);
  localparam integer LAST_I = `SBAS_TICK_CYC - 1;
  localparam [18:0]  LAST   = LAST_I[18:0];
  reg [18:0] cnt_q;
  reg        tick_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= 19'h00000;
      tick_q <= 1'b0;
    end else if (ce_i) begin
      tick_q <= (cnt_q == LAST);
      if (cnt_q == LAST) begin
        cnt_q <= 19'h00000;
      end else begin
        cnt_q <= cnt_q + 19'h00001;
      end
    end
  end

  assign tick_o = tick_q;
endmodule // sbas_tick

// >>> core/sbas_top.v
// Servo brake and alarm sequencer with a classic Wishbone register slave.
`timescale 1ns/100ps
`include "sbas_regs.vh"
// Summary of operation
// - brake output low releases, high applies
// - routing 0 none, 1-3 select circuit
// - shared output circuit is OR
// - standstill delay 0-50 ticks, default zero
// - zero delay de-energises with brake command
// - standstill delay only when stopped
// - alarm de-energises immediately, no delay
// - speed threshold 0-10000 rpm, default 100
// - running timeout 0-100 ticks, default 50
// - running brake at low speed or timeout
// - threshold clamps to motor maximum speed
// - fault output low normal, high alarm
// - three-bit fault code outputs
// - fault clear input resets latched alarm
// - encoder alarms clear only at power-up
// - position mode blanks the code pins on trajectory errors
// - enable low energises, high stops motor
// - servo-off on enable loss or alarm
// - enable mapping 7 forces enable active
module sbas_top (
  // System.
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  // Wishbone slave.
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [5:2]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // Pins from host and motor logic.
  input  wire        servo_enable_n_i,
  input  wire        fault_clear_in_i,
  input  wire        fault_event_i,
  input  wire [2:0]  fault_event_code_i,
  input  wire        fault_event_enc_i,
  input  wire        fault_event_traj_i,
  input  wire [15:0] motor_speed_i,
  // Pins to motor and host.
  output reg         motor_energise_o,
  output reg  [2:0]  out_circuit_n_o,
  output reg         fault_out_o,
  output reg  [2:0]  fault_code_o
);
  // One-hot sequencer states.
  localparam [4:0] ST_ON   = 5'b00001;
  localparam [4:0] ST_STOP = 5'b00010;
  localparam [4:0] ST_RUN  = 5'b00100;
  localparam [4:0] ST_OFF  = 5'b01000;
  localparam [4:0] ST_INIT = 5'b10000;

  ////////////////////////////////////////////////////////////////////////////
  // Magnitude of the signed speed, saturated to the 14-bit threshold range.
  function [13:0] abs_speed;
    input [15:0] v;
    reg   [15:0] m;
    begin
      m = v[15] ? (~v + 16'h0001) : v;
      abs_speed = (m[15:14] != 2'h0) ? 14'h3FFF : m[13:0];
    end
  endfunction

  function [13:0] clip14;
    input [13:0] v;
    input [13:0] lim;
    begin
      clip14 = (v > lim) ? lim : v;
    end
  endfunction

  // Saturate a whole written word to a ceiling, so an over-range delay, speed or timeout setting clamps.
  function [13:0] sat_word;
    input [31:0] v;
    input [13:0] lim;
    begin
      sat_word = ((v[31:14] != 18'h00000) || (v[13:0] > lim)) ? lim : v[13:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  wire       tick;
  wire       en_n_s;
  wire       clr_s;
  // One pulse every 10 ms paces the delay and timeout counters and the speed sample.
  sbas_tick u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .tick_o (tick)
  );
  // Both pins pass two flip-flops untouched; after reset enable reads inactive and clear reads idle.
  sbas_sync #(.W(2)) u_sync (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .rst_val_i (2'h2),
    .async_i   ({servo_enable_n_i, fault_clear_in_i}),
    .sync_o    ({en_n_s, clr_s})
  );
  wire clr_req = clr_s;

  ////////////////////////////////////////////////////////////////////////////
  reg [1:0]  route_q;
  reg [2:0]  enmap_q;
  reg        posmode_q;
  reg [2:0]  other_q;
  reg [5:0]  delay_q;
  reg [13:0] speed_q;
  reg [6:0]  tmo_q;
  reg [13:0] maxspd_q;
  reg        alarm_q;
  reg        enc_q;
  reg        traj_q;
  reg [2:0]  code_q;
  reg [4:0]  state_q;
  reg [6:0]  cnt_q;
  reg        brake_cmd_q;
  reg [13:0] spd_abs_q;

  // A write needs byte lane 0; wider fields take each upper lane only when it is selected.
  wire wb_req = cyc_i & stb_i & ~ack_o;
  wire wb_wr  = wb_req & we_i & sel_i[0];
  wire enable = (enmap_q == `SBAS_ENMAP_IGNORE) | ~en_n_s;
  wire servo_off_req = ~enable | alarm_q;
  wire [13:0] thr = clip14(speed_q, maxspd_q);
  wire [31:0] wr_word  = dat_i & {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, 8'hFF};
  wire [13:0] wr14     = wr_word[13:0];
  wire [13:0] delay_wr = sat_word(wr_word, {8'h00, `SBAS_DELAY_MAX});
  wire [13:0] speed_wr = sat_word(wr_word, `SBAS_SPEED_MAX);
  wire [13:0] tmo_wr   = sat_word(wr_word, {7'h00, `SBAS_TMO_MAX});
  wire [2:0]  vis_code = (posmode_q & traj_q) ? 3'h0 : code_q;

  // Reads answer one cycle after the request; the data stands for that cycle only.
  always @(posedge clk_i) begin
    if (rst_i) begin
      route_q   <= 2'h0;
      enmap_q   <= 3'h0;
      posmode_q <= 1'b0;
      other_q   <= 3'h0;
      delay_q   <= `SBAS_DELAY_RST;
      speed_q   <= `SBAS_SPEED_RST;
      tmo_q     <= `SBAS_TMO_RST;
      maxspd_q  <= `SBAS_MAXSPD_RST;
      ack_o     <= 1'b0;
      dat_o     <= 32'h00000000;
    end else if (ce_i) begin
      ack_o <= wb_req;
      if (wb_wr) begin
        case (adr_i)
          `SBAS_ADR_CTRL: begin
            route_q   <= dat_i[1:0];
            enmap_q   <= dat_i[4:2];
            posmode_q <= dat_i[5];
            other_q   <= {1'b0, dat_i[7:6]};
          end
          `SBAS_ADR_DELAY: delay_q <= delay_wr[5:0];
          `SBAS_ADR_SPEED: speed_q <= speed_wr;
          `SBAS_ADR_TMO: tmo_q <= tmo_wr[6:0];
          `SBAS_ADR_MAXSPD: maxspd_q <= wr14;
          default: ;
        endcase
      end
      if (wb_req) begin
        case (adr_i)
          `SBAS_ADR_CTRL: dat_o <= {24'h000000, other_q[1:0], posmode_q, enmap_q, route_q};
          `SBAS_ADR_DELAY: dat_o <= {26'h0000000, delay_q};
          `SBAS_ADR_SPEED: dat_o <= {18'h00000, speed_q};
          `SBAS_ADR_TMO: dat_o <= {25'h0000000, tmo_q};
          `SBAS_ADR_FAULT: dat_o <= {27'h0000000, traj_q, enc_q, code_q};
          `SBAS_ADR_STATUS: dat_o <= {24'h000000, alarm_q, brake_cmd_q, motor_energise_o, enable, state_q[3:0]};
          `SBAS_ADR_MAXSPD: dat_o <= {18'h00000, maxspd_q};
          default: dat_o <= 32'h00000000;
        endcase
      end else begin
        dat_o <= 32'h00000000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault latch: a new event wins over a clear in the same cycle.
  always @(posedge clk_i) begin
    if (rst_i) begin
      alarm_q <= 1'b0;
      enc_q   <= 1'b0;
      traj_q  <= 1'b0;
      code_q  <= 3'h0;
    end else if (ce_i) begin
      if (fault_event_i) begin
        alarm_q <= 1'b1;
        code_q  <= fault_event_code_i;
        enc_q   <= enc_q | fault_event_enc_i;
        traj_q  <= fault_event_traj_i;
      end else if (clr_req & alarm_q & ~enc_q) begin
        alarm_q <= 1'b0;
        code_q  <= 3'h0;
        traj_q  <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // At standstill the brake closes first and the motor is held for the delay.
  // While the motor turns it is released at once and the brake waits for low
  // speed or the timeout, whichever comes first.
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q     <= ST_INIT;
      cnt_q       <= 7'h00;
      brake_cmd_q <= 1'b1;
      spd_abs_q   <= 14'h0000;
    end else if (ce_i) begin
      if (tick) begin
        spd_abs_q <= abs_speed(motor_speed_i);
      end
      case (state_q)
        ST_INIT, ST_OFF: begin
          cnt_q       <= 7'h00;
          brake_cmd_q <= 1'b1;
          if (~servo_off_req) begin
            state_q     <= ST_ON;
            brake_cmd_q <= 1'b0;
          end
        end
        ST_ON: begin
          cnt_q       <= 7'h00;
          brake_cmd_q <= 1'b0;
          if (servo_off_req) begin
            if (spd_abs_q >= thr) begin
              state_q <= ST_RUN;
            end else begin
              brake_cmd_q <= 1'b1;
              state_q     <= (alarm_q || delay_q == 6'h00) ? ST_OFF : ST_STOP;
            end
          end
        end
        ST_STOP: begin
          if (~servo_off_req) begin
            state_q <= ST_ON;
            cnt_q   <= 7'h00;
          end else if (alarm_q || cnt_q[5:0] >= delay_q) begin
            state_q <= ST_OFF;
          end else if (tick) begin
            cnt_q <= cnt_q + 7'h01;
          end
        end
        ST_RUN: begin
          if (~servo_off_req) begin
            state_q <= ST_ON;
            cnt_q   <= 7'h00;
          end else if (spd_abs_q < thr || cnt_q >= tmo_q) begin
            brake_cmd_q <= 1'b1;
            state_q     <= ST_OFF;
          end else if (tick) begin
            cnt_q <= cnt_q + 7'h01;
          end
        end
        default: state_q <= ST_INIT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Motor is de-energised immediately on alarm and when running-off starts.
  // On a plain servo-off the motor drops the standstill delay after the routed brake
  // output opens, so a zero delay keeps both together.
  wire energise_d = ((state_q == ST_ON) | (state_q == ST_STOP)) & ~alarm_q;
  wire brake_rel  = ~brake_cmd_q;
  // Each circuit ORs every signal routed to it; a route of zero selects none.
  integer i;
  reg [2:0] circ_d;
  always @* begin
    circ_d = 3'h0;
    for (i = 0; i < 3; i = i + 1) begin
      if (route_q == i[1:0] + 2'h1) circ_d[i] = circ_d[i] | brake_rel;
      if (other_q[1:0] == i[1:0] + 2'h1) circ_d[i] = circ_d[i] | 1'b1;
    end
  end

  // Every pin is registered; the circuit and code outputs are low when active.
  always @(posedge clk_i) begin
    if (rst_i) begin
      motor_energise_o <= 1'b0;
      out_circuit_n_o  <= 3'h7;
      fault_out_o      <= 1'b0;
      fault_code_o     <= 3'h7;
    end else if (ce_i) begin
      motor_energise_o <= energise_d;
      out_circuit_n_o  <= ~circ_d;
      fault_out_o      <= alarm_q;
      fault_code_o     <= ~vis_code;
    end
  end
endmodule // sbas_top

// >>> verification/sbas_checker.sv
// Port checker for the brake and alarm sequencer.
`timescale 1ns/100ps
module sbas_checker (
  input logic        clk_i, rst_i, ce_i, cyc_i, stb_i, ack_o,
  input logic [31:0] dat_o,
  input logic        fault_event_i, fault_clear_in_i, motor_energise_o, fault_out_o,
  input logic [2:0]  out_circuit_n_o, fault_code_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_one; ack_o |=> !ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held too long");
  property p_ack_resp; cyc_i && stb_i && !ack_o && ce_i |=> ack_o; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("request not answered");
  property p_dat_idle; !ack_o |-> dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_alarm_stop; $rose(fault_event_i) |-> ##[1:3] (!motor_energise_o && fault_out_o); endproperty
  a_alarm_stop: assert property (p_alarm_stop) else $error("alarm did not stop motor");
  property p_alarm_dead; fault_out_o [*2] |-> !motor_energise_o; endproperty
  a_alarm_dead: assert property (p_alarm_dead) else $error("motor on during alarm");
  property p_code_idle; !fault_out_o [*2] |-> fault_code_o == 3'h7; endproperty
  a_code_idle: assert property (p_code_idle) else $error("code shown without alarm");
  property p_latch; !fault_clear_in_i [*5] ##0 fault_out_o |=> fault_out_o; endproperty
  a_latch: assert property (p_latch) else $error("alarm dropped without clear");
  property p_rst_out;
    $fell(rst_i) |-> !motor_energise_o && !fault_out_o && out_circuit_n_o == 3'h7 && fault_code_o == 3'h7;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not idle after reset");
  c_run: cover property ($rose(motor_energise_o));
  c_alarm: cover property ($rose(fault_out_o));
  c_clear: cover property ($fell(fault_out_o));
  c_runoff: cover property (!motor_energise_o && out_circuit_n_o == 3'h6 && !fault_out_o);
endmodule // sbas_checker

bind sbas_top sbas_checker u_chk (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .ack_o, .dat_o, .fault_event_i,
  .fault_clear_in_i, .motor_energise_o, .fault_out_o, .out_circuit_n_o, .fault_code_o);

// >>> verification/sbas_host_model.sv
// Host controller and brake relay seen from the sequencer pins.
`timescale 1ns/100ps
module sbas_host_model (
  input  logic        clk_i,
  input  logic        want_run_i,
  input  logic        fault_out_i,
  input  logic [2:0]  out_circuit_n_i,
  output logic        servo_enable_n_o = 1'b1,
  output logic [15:0] motor_speed_o = 16'h0000,
  output logic        relay_closed_o
);
  // The axis is held still, so enable is only dropped at standstill.
  always @(posedge clk_i) begin
    motor_speed_o <= 16'h0000;
    servo_enable_n_o <= !want_run_i || fault_out_i;
  end
  assign relay_closed_o = ~&out_circuit_n_i;
endmodule // sbas_host_model

// >>> verification/tb_servo_brake_alarm_sequencer.sv
// Self-checking bench for the servo brake and alarm sequencer.
`timescale 1ns/100ps
`include "sbas_regs.vh"
module tb_servo_brake_alarm_sequencer;
  logic clk_i = 0, rst_i = 1, ce_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, want_run = 0, relay;
  logic fault_event_i = 0, fault_clear_in_i = 0, fault_event_enc_i = 0, fault_event_traj_i = 0;
  logic [5:2] adr_i = '0;
  logic [3:0] sel_i = '0;
  logic [31:0] dat_i = '0, dat_o, seed = 32'hC, r, exp_q[$];
  logic ack_o, motor_energise_o, fault_out_o, servo_enable_n_i;
  logic [2:0] fault_event_code_i = '0, out_circuit_n_o, fault_code_o;
  logic [15:0] motor_speed_i;
  int miscompares = 0, check_count = 0;
  always #10 clk_i = ~clk_i;
  sbas_top u_dut (.*);
  sbas_host_model u_host (.clk_i, .want_run_i(want_run), .fault_out_i(fault_out_o),
    .out_circuit_n_i(out_circuit_n_o), .servo_enable_n_o(servo_enable_n_i),
    .motor_speed_o(motor_speed_i), .relay_closed_o(relay));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= we; adr_i <= a; sel_i <= 4'hF; dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  // Enable passes two sync stages, one state step and one output stage.
  task automatic settle();
    repeat (8) @(posedge clk_i);
  endtask
  task automatic pulse(input bit clr);
    if (clr) fault_clear_in_i <= 1'b1;
    else fault_event_i <= 1'b1;
    @(posedge clk_i);
    fault_clear_in_i <= 1'b0;
    fault_event_i <= 1'b0;
    settle();
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk_i) if (ack_o === 1'b1 && we_i === 1'b0) chk(dat_o, exp_q.pop_front());
  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(`SBAS_ADR_DELAY, 32'h0);
    rd(`SBAS_ADR_SPEED, 32'h64);
    rd(`SBAS_ADR_TMO, 32'h32);
    rd(`SBAS_ADR_MAXSPD, 32'h1770);
    wb(1'b1, `SBAS_ADR_DELAY, 32'h3F); rd(`SBAS_ADR_DELAY, 32'h32);
    wb(1'b1, `SBAS_ADR_SPEED, 32'h3FFF); rd(`SBAS_ADR_SPEED, 32'h2710);
    wb(1'b1, `SBAS_ADR_TMO, 32'h7F); rd(`SBAS_ADR_TMO, 32'h64);
    r = rnd() % 51;
    wb(1'b1, `SBAS_ADR_DELAY, r); rd(`SBAS_ADR_DELAY, r);
    wb(1'b1, 4'hF, 32'hA5); rd(4'hF, 32'h0);
    wb(1'b1, `SBAS_ADR_DELAY, 32'h0);
    want_run <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, `SBAS_ADR_CTRL, k);
      settle();
      chk(motor_energise_o, 1);
      chk(out_circuit_n_o, k ? 3'h7 ^ (3'h1 << (k - 1)) : 3'h7);
      chk(relay, k != 0);
    end
    wb(1'b1, `SBAS_ADR_CTRL, 32'h1);
    want_run <= 1'b0;
    settle();
    chk(motor_energise_o, 0);
    chk(out_circuit_n_o, 3'h7);
    wb(1'b1, `SBAS_ADR_CTRL, 32'h82);
    settle();
    chk(out_circuit_n_o, 3'h5);
    wb(1'b1, `SBAS_ADR_DELAY, 32'h5);
    wb(1'b1, `SBAS_ADR_CTRL, 32'h1);
    want_run <= 1'b1;
    settle();
    chk(out_circuit_n_o, 3'h6);
    want_run <= 1'b0;
    settle();
    chk(motor_energise_o, 1);
    chk(out_circuit_n_o, 3'h7);
    wb(1'b1, `SBAS_ADR_DELAY, 32'h0);
    settle();
    chk(motor_energise_o, 0);
    wb(1'b1, `SBAS_ADR_MAXSPD, 32'h0);
    want_run <= 1'b1;
    settle();
    chk(motor_energise_o, 1);
    want_run <= 1'b0;
    settle();
    chk(motor_energise_o, 0);
    chk(out_circuit_n_o, 3'h6);
    wb(1'b1, `SBAS_ADR_TMO, 32'h0);
    settle();
    chk(out_circuit_n_o, 3'h7);
    wb(1'b1, `SBAS_ADR_MAXSPD, 32'h1770);
    wb(1'b1, `SBAS_ADR_CTRL, 32'h1C);
    settle();
    chk(motor_energise_o, 1);
    r = rnd() % 7 + 1;
    fault_event_code_i <= r[2:0];
    pulse(1'b0);
    chk(motor_energise_o, 0);
    chk(fault_out_o, 1);
    chk(fault_code_o, r[2:0] ^ 3'h7);
    rd(`SBAS_ADR_FAULT, r[2:0]);
    pulse(1'b1);
    chk(fault_out_o, 0);
    chk(fault_code_o, 3'h7);
    chk(motor_energise_o, 1);
    wb(1'b1, `SBAS_ADR_CTRL, 32'h3C);
    fault_event_traj_i <= 1'b1;
    fault_event_code_i <= 3'h5;
    pulse(1'b0);
    chk(fault_code_o, 3'h7);
    chk(fault_out_o, 1);
    fault_event_traj_i <= 1'b0;
    pulse(1'b1);
    fault_event_enc_i <= 1'b1;
    pulse(1'b0);
    fault_event_enc_i <= 1'b0;
    pulse(1'b1);
    chk(fault_out_o, 1);
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
    chk(fault_out_o, 0);
    chk(motor_energise_o, 0);
    wrap_up();
  end
endmodule // tb_servo_brake_alarm_sequencer
